// [tdp_policy.sv]
// disconnect and reselection policy of a parallel bus target
// assumes APB from software and same-clock phase strobes from the
// target sequencer; bus phase sequencing itself lives elsewhere
`default_nettype none
module tdp_policy #(
    parameter int TICK_CYCLES = tdp_pkg::TICK_CYCLES
) (
    input  wire logic                       ref_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       ce,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [tdp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output var  logic [31:0]                prdata,
    output var  logic                       pready,
    output var  logic                       pslverr,
    input  wire logic                       disc_priv,
    input  wire logic                       bsy_owned,
    input  wire logic                       req_ack,
    input  wire logic                       cmd_phase_done,
    input  wire logic                       data_phase,
    input  wire logic                       data_all_moved,
    input  wire logic                       cmd_complete,
    input  wire logic                       bus_released,
    input  wire logic                       mdp_rejected,
    output var  logic                       disconnect_req,
    output var  logic                       reselect_ok,
    output var  logic                       mdp_allow,
    output var  logic                       check_cond,
    output var  logic [3:0]                 sense_key,
    output var  logic [7:0]                 sense_code,
    output var  logic                       irq
);
    localparam int LW = tdp_pkg::LIM_W;
    localparam int HI = tdp_pkg::HI_LSB;
    localparam int EN = tdp_pkg::EV_N;

    tdp_timer_if #(.N(tdp_pkg::N_TIMERS), .W(tdp_pkg::CNT_W)) tif ();

    tdp_timers #(.TICK_CYCLES(TICK_CYCLES)) u_timers (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .t       (tif.tmr)
    );

    // register state
    logic [31:0]               cfg0_ff, cfg1_ff, act0_ff, act1_ff;
    logic [31:0]               nxt_cfg0, nxt_cfg1, nxt_act0, nxt_act1;
    logic [tdp_pkg::CFG2_W-1:0] cfg2_ff, act2_ff, nxt_cfg2, nxt_act2;
    logic [EN-1:0]             stat_ff, mask_ff, nxt_stat, nxt_mask;
    logic [31:0]               prdata_ff, nxt_prdata;
    logic                      pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
    logic                      chk_ff, irq_ff, nxt_chk, nxt_irq;
    logic [3:0]                skey_ff, nxt_skey;
    logic [7:0]                scode_ff, nxt_scode;
    // policy state
    tdp_pkg::tdp_state_e       state_ff, nxt_state;
    logic                      disc_ff, resel_ff, nxt_disc, nxt_resel;
    logic                      open_ff, started_ff, moved_ff;
    logic                      nxt_open, nxt_started, nxt_moved;
    logic [tdp_pkg::BURST_W-1:0] bytes_ff, nxt_bytes;
    // decode helpers
    logic                      acc, commit, illegal, legal_pol;
    logic [2:0]                pol, sh_pol;
    logic [LW-1:0]             inact_lim, conn_lim, disc_lim, burst_lim;
    logic                      pma, dac, lock, allowed;
    logic [EN-1:0]             ev;

    assign acc       = psel && penable && pready_ff;
    assign commit    = acc && pwrite && (paddr == tdp_pkg::A_CMD)
                       && pwdata[tdp_pkg::COMMIT_BIT];
    assign sh_pol    = cfg2_ff[tdp_pkg::POL_LSB +: 3];
    assign legal_pol = (sh_pol == tdp_pkg::POL_NONE)
                       || (sh_pol == tdp_pkg::POL_DATA)
                       || (sh_pol == tdp_pkg::POL_CMD);
    // foreign flag says another page field held a nonzero value
    assign illegal   = pwdata[tdp_pkg::FOREIGN_BIT] || !legal_pol
                       || ((sh_pol != tdp_pkg::POL_NONE)
                           && (cfg1_ff[HI +: LW] != '0));

    assign inact_lim = act0_ff[LW-1:0];
    assign conn_lim  = act0_ff[HI +: LW];
    assign disc_lim  = act1_ff[LW-1:0];
    assign burst_lim = act1_ff[HI +: LW];
    assign pol       = act2_ff[tdp_pkg::POL_LSB +: 3];
    assign pma       = act2_ff[tdp_pkg::PMA_BIT];
    assign dac       = act2_ff[tdp_pkg::DAC_BIT];

    // holds of the data-transfer policy; 000b never locks
    assign lock = started_ff
        && (((pol == tdp_pkg::POL_DATA) && !moved_ff)
            || (pol == tdp_pkg::POL_CMD));
    assign allowed = disc_priv && (state_ff == tdp_pkg::ST_CONN)
                     && !disc_ff;

    // timer hookup
    always_comb begin
        tif.run[tdp_pkg::T_INACT]     = (state_ff == tdp_pkg::ST_CONN)
                                        && !lock;
        tif.restart[tdp_pkg::T_INACT] = req_ack
                                        || (state_ff != tdp_pkg::ST_CONN);
        tif.run[tdp_pkg::T_CONN]      = (state_ff == tdp_pkg::ST_CONN)
                                        && !lock;
        tif.restart[tdp_pkg::T_CONN]  = (state_ff != tdp_pkg::ST_CONN);
        tif.run[tdp_pkg::T_DISC]      = (state_ff == tdp_pkg::ST_WAIT);
        tif.restart[tdp_pkg::T_DISC]  = bus_released;
        tif.limit[tdp_pkg::T_INACT]   = {1'b0, inact_lim};
        tif.limit[tdp_pkg::T_CONN]    = {1'b0, conn_lim};
        // one extra unit so a partial first tick never shortens the wait
        tif.limit[tdp_pkg::T_DISC]    = (disc_lim == '0) ? '0
                                        : {1'b0, disc_lim} + 1'b1;
    end

    // disconnect triggers, plus the illegal-page and pointer-reject status events
    always_comb begin
        ev = '0;
        ev[tdp_pkg::EV_INACT] = allowed && !lock && (inact_lim != '0)
                                && tif.expired[tdp_pkg::T_INACT];
        ev[tdp_pkg::EV_CONN]  = allowed && !lock && (conn_lim != '0)
                                && tif.expired[tdp_pkg::T_CONN];
        ev[tdp_pkg::EV_BURST] = allowed && data_phase
            && (burst_lim != '0)
            && (bytes_ff >= {burst_lim, {tdp_pkg::BURST_SHIFT{1'b0}}});
        ev[tdp_pkg::EV_DAC]   = allowed && dac && cmd_phase_done;
        ev[tdp_pkg::EV_ILLEGAL] = commit && illegal;
        ev[tdp_pkg::EV_MDPREJ]  = mdp_rejected && pma;
    end

    // register file and APB slave
    always_comb begin
        nxt_cfg0    = cfg0_ff;
        nxt_cfg1    = cfg1_ff;
        nxt_cfg2    = cfg2_ff;
        nxt_act0    = act0_ff;
        nxt_act1    = act1_ff;
        nxt_act2    = act2_ff;
        nxt_mask    = mask_ff;
        nxt_stat    = stat_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = pslverr_ff;
        nxt_pready  = psel && !penable && !pready_ff;
        nxt_chk     = 1'b0;
        nxt_skey    = skey_ff;
        nxt_scode   = scode_ff;
        if (psel && !penable) begin
            nxt_pslverr = 1'b0;
            if (paddr == tdp_pkg::A_CFG0) begin
                nxt_prdata = cfg0_ff;
            end else if (paddr == tdp_pkg::A_CFG1) begin
                nxt_prdata = cfg1_ff;
            end else if (paddr == tdp_pkg::A_CFG2) begin
                nxt_prdata = 32'(cfg2_ff);
            end else if (paddr == tdp_pkg::A_CMD) begin
                nxt_prdata = 32'h0000_0000;
            end else if (paddr == tdp_pkg::A_STAT) begin
                nxt_prdata = 32'(stat_ff);
            end else if (paddr == tdp_pkg::A_MASK) begin
                nxt_prdata = 32'(mask_ff);
            end else if (paddr == tdp_pkg::A_STATE) begin
                nxt_prdata = {14'h0000, resel_ff, disc_ff, scode_ff,
                              skey_ff, 2'h0, state_ff};
            end else begin
                nxt_prdata  = 32'h0000_0000;
                nxt_pslverr = 1'b1;
            end
        end
        if (acc && pwrite) begin
            if (paddr == tdp_pkg::A_CFG0) begin
                nxt_cfg0 = pwdata;
            end else if (paddr == tdp_pkg::A_CFG1) begin
                nxt_cfg1 = pwdata;
            end else if (paddr == tdp_pkg::A_CFG2) begin
                nxt_cfg2 = pwdata[tdp_pkg::CFG2_W-1:0];
            end else if (paddr == tdp_pkg::A_STAT) begin
                nxt_stat = stat_ff & ~pwdata[EN-1:0];
            end else if (paddr == tdp_pkg::A_MASK) begin
                nxt_mask = pwdata[EN-1:0];
            end
        end
        if (mdp_rejected && pma) begin
            nxt_chk   = 1'b1;
            nxt_skey  = tdp_pkg::SK_ABORTED;
            nxt_scode = tdp_pkg::ASC_BAD_MSG;
        end
        // an illegal page keeps the old settings in force
        if (commit && illegal) begin
            nxt_chk   = 1'b1;
            nxt_skey  = tdp_pkg::SK_ILLEGAL_REQ;
            nxt_scode = tdp_pkg::ASC_BAD_FIELD;
        end else if (commit) begin
            nxt_act0 = cfg0_ff;
            nxt_act1 = cfg1_ff;
            nxt_act2 = cfg2_ff;
        end
        // set beats a clear in the same cycle
        nxt_stat = nxt_stat | ev;
        nxt_irq  = |(nxt_stat & nxt_mask);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg0_ff    <= '0;
            cfg1_ff    <= '0;
            cfg2_ff    <= '0;
            act0_ff    <= '0;
            act1_ff    <= '0;
            act2_ff    <= '0;
            stat_ff    <= '0;
            mask_ff    <= '0;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            chk_ff     <= 1'b0;
            skey_ff    <= '0;
            scode_ff   <= '0;
            irq_ff     <= 1'b0;
        end else if (ce) begin
            cfg0_ff    <= nxt_cfg0;
            cfg1_ff    <= nxt_cfg1;
            cfg2_ff    <= nxt_cfg2;
            act0_ff    <= nxt_act0;
            act1_ff    <= nxt_act1;
            act2_ff    <= nxt_act2;
            stat_ff    <= nxt_stat;
            mask_ff    <= nxt_mask;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            chk_ff     <= nxt_chk;
            skey_ff    <= nxt_skey;
            scode_ff   <= nxt_scode;
            irq_ff     <= nxt_irq;
        end
    end

    // connection state
    always_comb begin
        nxt_state   = state_ff;
        nxt_disc    = disc_ff;
        nxt_open    = open_ff;
        nxt_started = started_ff;
        nxt_moved   = moved_ff;
        nxt_bytes   = bytes_ff;
        if (|ev[tdp_pkg::EV_DAC:tdp_pkg::EV_INACT]) begin
            nxt_disc = 1'b1;
        end
        if (bus_released) begin
            nxt_disc = 1'b0;
        end
        if (cmd_phase_done) begin
            nxt_open = 1'b1;
        end
        if (data_phase) begin
            nxt_started = 1'b1;
        end
        if (data_all_moved) begin
            nxt_moved = 1'b1;
        end
        if (cmd_complete) begin
            nxt_open    = 1'b0;
            nxt_started = 1'b0;
            nxt_moved   = 1'b0;
        end
        if (!data_phase || bus_released) begin
            nxt_bytes = '0;
        end else if (req_ack && !(&bytes_ff)) begin
            nxt_bytes = bytes_ff + 1'b1;
        end
        case (state_ff)
            tdp_pkg::ST_IDLE, tdp_pkg::ST_RESEL: begin
                if (bsy_owned) begin
                    nxt_state = tdp_pkg::ST_CONN;
                end
            end
            tdp_pkg::ST_CONN: begin
                if (bus_released) begin
                    nxt_state = nxt_open ? tdp_pkg::ST_WAIT
                                         : tdp_pkg::ST_IDLE;
                end
            end
            default: begin
                if (bsy_owned) begin
                    nxt_state = tdp_pkg::ST_CONN;
                end else if (tif.expired[tdp_pkg::T_DISC]) begin
                    nxt_state = tdp_pkg::ST_RESEL;
                end
            end
        endcase
        nxt_resel = (nxt_state == tdp_pkg::ST_RESEL);
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff   <= tdp_pkg::ST_IDLE;
            disc_ff    <= 1'b0;
            resel_ff   <= 1'b0;
            open_ff    <= 1'b0;
            started_ff <= 1'b0;
            moved_ff   <= 1'b0;
            bytes_ff   <= '0;
        end else if (ce) begin
            state_ff   <= nxt_state;
            disc_ff    <= nxt_disc;
            resel_ff   <= nxt_resel;
            open_ff    <= nxt_open;
            started_ff <= nxt_started;
            moved_ff   <= nxt_moved;
            bytes_ff   <= nxt_bytes;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign disconnect_req = disc_ff;
    assign reselect_ok    = resel_ff;
    assign mdp_allow      = act2_ff[tdp_pkg::PMA_BIT];
    assign check_cond     = chk_ff;
    assign sense_key      = skey_ff;
    assign sense_code     = scode_ff;
    assign irq            = irq_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_inact_fire: assert property (
        (ce && allowed && !lock && inact_lim != '0
         && tif.expired[tdp_pkg::T_INACT] && !bus_released)
        |=> disc_ff && stat_ff[tdp_pkg::EV_INACT])
        else $error("inactivity overrun not acted on");
    chk_conn_fire: assert property (
        (ce && allowed && !lock && conn_lim != '0
         && tif.expired[tdp_pkg::T_CONN] && !bus_released)
        |=> disc_ff && stat_ff[tdp_pkg::EV_CONN])
        else $error("connect limit not acted on");
    chk_no_priv: assert property (
        (ce && !disc_priv && !disc_ff) |=> !disc_ff)
        else $error("disconnect without privilege");
    chk_data_hold: assert property (
        (ce && lock && !disc_ff && !cmd_phase_done && burst_lim == '0)
        |=> !disc_ff)
        else $error("disconnect during locked transfer");
    chk_resel_wait: assert property (
        (ce && state_ff == tdp_pkg::ST_WAIT && !bsy_owned
         && !tif.expired[tdp_pkg::T_DISC]) |=> !resel_ff)
        else $error("reselect before wait elapsed");
    chk_burst_fire: assert property (
        (ce && ev[tdp_pkg::EV_BURST] && !bus_released) |=> disc_ff ##0
        stat_ff[tdp_pkg::EV_BURST])
        else $error("burst limit not acted on");
    chk_dac_fire: assert property (
        (ce && allowed && dac && cmd_phase_done && !bus_released)
        |=> disc_ff && stat_ff[tdp_pkg::EV_DAC])
        else $error("no disconnect after command");
    chk_mdp_gate: assert property (
        $rose(mdp_allow) |-> $past(commit) && $past(!illegal))
        else $error("pointer modify allowed without commit");
    chk_mdp_reject: assert property (
        (ce && mdp_rejected && pma && !commit) |=> check_cond
        && sense_key == tdp_pkg::SK_ABORTED
        && sense_code == tdp_pkg::ASC_BAD_MSG)
        else $error("rejected pointer modify not reported");
    chk_illegal_cfg: assert property (
        (ce && commit && illegal) |=> check_cond
        && sense_key == tdp_pkg::SK_ILLEGAL_REQ
        && sense_code == tdp_pkg::ASC_BAD_FIELD
        && act2_ff == $past(act2_ff) && act1_ff == $past(act1_ff))
        else $error("illegal page not rejected");
    chk_apb_wait: assert property (
        (ce && psel && !penable && !pready_ff) |=> pready_ff ##1 !pready)
        else $error("apb answer not in one cycle");
endmodule
`default_nettype wire

// [tdp_pkg.sv]
// constants, register map and types of the disconnect policy block
// assumes a 125 MHz core clock and an APB master with 32-bit data
`default_nettype none
package tdp_pkg;
    localparam int ADDR_W      = 8;
    localparam int LIM_W       = 16;
    localparam int CNT_W       = LIM_W + 1;
    localparam int BURST_SHIFT = 9;
    localparam int BURST_W     = LIM_W + BURST_SHIFT;
    localparam int N_TIMERS    = 3;
    // tick period in microseconds, clock rate in MHz
    localparam int TICK_US     = 100;
    localparam int CLK_MHZ     = 125;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // timer slots
    localparam int T_INACT = 0;
    localparam int T_CONN  = 1;
    localparam int T_DISC  = 2;
    // register byte addresses
    localparam logic [ADDR_W-1:0] A_CFG0  = 8'h00;
    localparam logic [ADDR_W-1:0] A_CFG1  = 8'h04;
    localparam logic [ADDR_W-1:0] A_CFG2  = 8'h08;
    localparam logic [ADDR_W-1:0] A_CMD   = 8'h0C;
    localparam logic [ADDR_W-1:0] A_STAT  = 8'h10;
    localparam logic [ADDR_W-1:0] A_MASK  = 8'h14;
    localparam logic [ADDR_W-1:0] A_STATE = 8'h18;
    // field positions
    localparam int HI_LSB     = 16;
    localparam int POL_LSB    = 0;
    localparam int PMA_BIT    = 3;
    localparam int DAC_BIT    = 4;
    localparam int CFG2_W     = 5;
    localparam int COMMIT_BIT = 0;
    localparam int FOREIGN_BIT = 1;
    // status / mask bits
    localparam int EV_INACT   = 0;
    localparam int EV_CONN    = 1;
    localparam int EV_BURST   = 2;
    localparam int EV_DAC     = 3;
    localparam int EV_ILLEGAL = 4;
    localparam int EV_MDPREJ  = 5;
    localparam int EV_N       = 6;
    // transfer disconnect policy codes
    localparam logic [2:0] POL_NONE = 3'h0;
    localparam logic [2:0] POL_DATA = 3'h1;
    localparam logic [2:0] POL_CMD  = 3'h3;
    // sense key and additional sense codes
    localparam logic [3:0] SK_ILLEGAL_REQ = 4'h5;
    localparam logic [3:0] SK_ABORTED     = 4'hB;
    localparam logic [7:0] ASC_BAD_FIELD  = 8'h26;
    localparam logic [7:0] ASC_BAD_MSG    = 8'h49;
    typedef enum logic [1:0] {ST_IDLE, ST_CONN, ST_WAIT, ST_RESEL} tdp_state_e;
endpackage
`default_nettype wire

// [tdp_timer_if.sv]
// signals between the policy core and its limit timers
// assumes both ends run on the same core clock
`default_nettype none
interface tdp_timer_if #(
    parameter int N = 3,
    parameter int W = 17
);
    logic         tick;
    logic [N-1:0] run;
    logic [N-1:0] restart;
    logic [N-1:0] expired;
    logic [W-1:0] limit [N];
    modport ctl (output run, output restart, output limit,
                 input expired, input tick);
    modport tmr (input run, input restart, input limit,
                 output expired, output tick);
endinterface
`default_nettype wire

// [tdp_timers.sv]
// shared 100 us tick and the saturating limit counters
// assumes restart and run come from logic on ref_clk
`default_nettype none
module tdp_timers #(
    parameter int TICK_CYCLES = tdp_pkg::TICK_CYCLES,
    parameter int N           = tdp_pkg::N_TIMERS,
    parameter int W           = tdp_pkg::CNT_W
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    tdp_timer_if.tmr  t
);
    localparam int PW = $clog2(TICK_CYCLES);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

    logic [PW-1:0] pre_ff;
    logic [PW-1:0] nxt_pre;
    logic          tick_ff;
    logic          nxt_tick;

    always_comb begin
        nxt_tick = (pre_ff == PRE_LAST);
        nxt_pre  = nxt_tick ? '0 : pre_ff + 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pre_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (ce) begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end

    assign t.tick = tick_ff;

    // the tick phase is free running, so a limit lands within one unit
    for (genvar i = 0; i < N; i++) begin : g_tmr
        logic [W-1:0] cnt_ff;
        logic [W-1:0] nxt_cnt;
        always_comb begin
            nxt_cnt = cnt_ff;
            if (t.restart[i]) begin
                nxt_cnt = '0;
            end else if (t.run[i] && tick_ff && !(&cnt_ff)) begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                cnt_ff <= '0;
            end else if (ce) begin
                cnt_ff <= nxt_cnt;
            end
        end
        assign t.expired[i] = t.run[i] && (cnt_ff >= t.limit[i]);

        chk_timer_restart: assert property (@(posedge ref_clk)
            disable iff (sys_rst) (ce && t.restart[i]) |=> cnt_ff == '0)
            else $error("timer did not restart");
    end
endmodule
`default_nettype wire

// [tdp_initiator.sv]
// initiator model: grants disconnect privilege and rejects pointer moves
// assumes the bench asks for each pointer message on the core clock
`default_nettype none
module tdp_initiator (
    input  wire logic ref_clk,
    input  wire logic grant,
    input  wire logic send_mdp,
    input  wire logic mdp_allow,
    output var  logic disc_priv,
    output var  logic mdp_rejected
);
    timeunit 1ns;
    timeprecision 1ps;
    initial disc_priv = 1'b0;
    initial mdp_rejected = 1'b0;
    always @(posedge ref_clk) begin
        disc_priv <= grant;
        // a message is only sent, and so rejected, while allowed
        mdp_rejected <= send_mdp && mdp_allow;
    end
endmodule
`default_nettype wire

// [target_disconnect_policy_tb.sv]
// bench for the disconnect policy block: apb calls and phase pulses
// assumes the initiator model answers on the same core clock
`default_nettype none
module target_disconnect_policy_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 0, sys_rst = 1, psel = 0, penable = 0;
    logic        pwrite = 0, bsy = 0, grant = 0, err, cc_seen = 0, dph = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [5:0]  ev = 6'h00;
    logic        pready, pslverr, dp, rej, dreq, rok, pma, cc, irq;
    logic [3:0]  sk;
    logic [7:0]  sc;
    logic [31:0] c1[4] = '{32'h10000, 0, 0, 0};
    logic [31:0] c2[4] = '{32'h9, 32'hA, 32'hC, 32'h8};
    logic [31:0] cm[4] = '{1, 1, 1, 3};
    int          fail_count = 0, comparisons = 0, cyc = 0, n;
    always #4 ref_clk = ~ref_clk;
    // short tick keeps the wait test to a few dozen cycles
    tdp_policy #(.TICK_CYCLES(10)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .disc_priv(dp), .bsy_owned(bsy), .req_ack(ev[0]),
        .cmd_phase_done(ev[1]), .data_phase(dph), .data_all_moved(ev[2]),
        .cmd_complete(ev[3]), .bus_released(ev[4]), .mdp_rejected(rej),
        .disconnect_req(dreq), .reselect_ok(rok), .mdp_allow(pma),
        .check_cond(cc), .sense_key(sk), .sense_code(sc), .irq(irq));
    tdp_initiator host (.ref_clk(ref_clk), .grant(grant), .send_mdp(ev[5]),
        .mdp_allow(pma), .disc_priv(dp), .mdp_rejected(rej));
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one idle edge after each transfer so psel is never set twice at once
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        // data and error are taken at the edge that samples pready high
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask
    task automatic pulse(input int i);
        ev[i] <= 1;
        @(posedge ref_clk);
        ev[i] <= 0;
        repeat (2) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cc === 1'b1) cc_seen <= 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 0;
        @(posedge ref_clk);
        apb(0, tdp_pkg::A_STATE, 0);
        chk("state", 0, r);
        apb(0, 8'h40, 0);
        chk("slverr", 1, {31'h0, err});
        $display("reset test done");
        foreach (c2[i]) begin
            apb(1, tdp_pkg::A_CFG1, c1[i]);
            apb(1, tdp_pkg::A_CFG2, c2[i]);
            cc_seen = 0;
            apb(1, tdp_pkg::A_CMD, cm[i]);
            apb(0, tdp_pkg::A_STATE, 0);
            chk("check_cond", 1, {31'h0, cc_seen});
            chk("sense", 32'h2650, r & 32'hFFF0);
            chk("allow", 0, {31'h0, pma});
            apb(1, tdp_pkg::A_STAT, 32'h3F);
        end
        $display("illegal page test done");
        apb(1, tdp_pkg::A_CFG1, 2);
        apb(1, tdp_pkg::A_CFG2, 32'h18);
        apb(1, tdp_pkg::A_CMD, 1);
        apb(1, tdp_pkg::A_MASK, 32'h8);
        chk("allow", 1, {31'h0, pma});
        grant <= 1;
        bsy <= 1;
        repeat (2) @(posedge ref_clk);
        pulse(1);
        chk("disc_req", 1, {31'h0, dreq});
        chk("irq", 1, {31'h0, irq});
        bsy <= 0;
        ev[4] <= 1;
        @(posedge ref_clk);
        ev[4] <= 0;
        n = 0;
        while (rok !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        // two ticks of ten cycles plus one tick of phase slack
        chk("wait", 1, {31'h0, n >= 20 && n <= 32});
        chk("disc_req", 0, {31'h0, dreq});
        @(posedge ref_clk);
        apb(1, tdp_pkg::A_STAT, 32'h8);
        chk("irq", 0, {31'h0, irq});
        $display("disconnect test done");
        cc_seen = 0;
        ev[5] <= 1;
        @(posedge ref_clk);
        ev[5] <= 0;
        repeat (3) @(posedge ref_clk);
        apb(0, tdp_pkg::A_STATE, 0);
        chk("sense", 32'h49B0, r & 32'hFFF0);
        chk("check_cond", 1, {31'h0, cc_seen});
        chk("sense_key", 32'hB, {28'h0, sk});
        chk("sense_code", 32'h49, {24'h0, sc});
        $display("pointer reject test done");
        apb(1, tdp_pkg::A_CFG1, 32'h10000);
        apb(1, tdp_pkg::A_CFG2, 0);
        apb(1, tdp_pkg::A_CMD, 1);
        bsy <= 1;
        dph <= 1;
        ev[0] <= 1;
        n = 0;
        while (dreq !== 1'b1 && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        // one negedge before the first handshake, 512 handshake edges, then one edge to request
        chk("burst", 514, n);
        @(posedge ref_clk);
        ev <= 6'h08;
        dph <= 0;
        @(posedge ref_clk);
        bsy <= 0;
        ev <= 6'h10;
        @(posedge ref_clk);
        ev <= 6'h00;
        apb(1, tdp_pkg::A_CFG0, 1);
        apb(1, tdp_pkg::A_CFG1, 0);
        apb(1, tdp_pkg::A_CFG2, 1);
        apb(1, tdp_pkg::A_CMD, 1);
        bsy <= 1;
        dph <= 1;
        // no handshakes: only the data lock keeps the request down
        repeat (40) @(posedge ref_clk);
        chk("locked", 0, {31'h0, dreq});
        pulse(2);
        repeat (10) @(posedge ref_clk);
        chk("inactive", 1, {31'h0, dreq});
        apb(0, tdp_pkg::A_STAT, 0);
        chk("status", 32'h5, r & 32'h7);
        $display("burst and inactivity test done");
        end_sim();
    end
endmodule
`default_nettype wire
